/* File: pkg/acrb_pkg.sv */
// Purpose: Constants and types shared by the front-end control register bank.
// Assumes: 200 MHz device clock, 7-bit register addresses, 8-bit register data.
// Notes: Offsets, field positions, reset values and cycle counts live here only.
// Notes on behaviour
// - Streaming control bit 7 picks stream type: 0 normal (reset), 1 controlled.
// - Streaming control bits 6..0 hold controlled stream length, reset zero.
// - Writing power field requests mode: 0 active, 1 power-down, 3 standby.
// - Reading power field gives mode in effect, same coding, active after reset.
// - Seven-bit data-only start address field, reset value 0x1A.
// - Three-bit data-only byte count is value plus one bytes, reset 0x2.
// - Writing 1 to restart bit 0 restarts conversion; bits 7..1 reserved.
// - Direction bit per pin 0..6: 0 input, 1 output; all reset as inputs.
// - Pin six carrying data ready is never used as general pin.
// - Writing pin level bit drives that pin low for 0, high for 1.
// - Reading output pin gives present value; writes to input pins ignored quietly.
// - Calibration scheme: 0 off (reset), 1, 2 and 3 select correction schemes.
// - Ready control bit 7 routes data ready onto pin six; clear keeps general pin.
// - Ready control bit 5 clear: CRC cleared on data ready deassertion; set suppresses.
// - Ready control bit 3 picks gain error source: 0 device corrects, 1 last coefficients.
// - Link reset enable is locked once written until register reset clears both.
package acrb_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [6:0] OFS_LINK_RST = 7'h02;
  localparam logic [6:0] OFS_STREAM = 7'h03;
  localparam logic [6:0] OFS_POWER = 7'h08;
  localparam logic [6:0] OFS_DO_START = 7'h09;
  localparam logic [6:0] OFS_DO_LEN = 7'h0A;
  localparam logic [6:0] OFS_RESTART = 7'h0B;
  localparam logic [6:0] OFS_PIN_DIR = 7'h0E;
  localparam logic [6:0] OFS_PIN_DAT = 7'h0F;
  localparam logic [6:0] OFS_BGCAL = 7'h10;
  localparam logic [6:0] OFS_READY_CTL = 7'h11;

  // ==========================================================================
  // Field positions.
  localparam int unsigned LINK_RST_BIT = 0;
  localparam int unsigned STRM_KIND_BIT = 7;
  localparam int unsigned RESTART_BIT = 0;
  localparam int unsigned READY_PIN6_BIT = 7;
  localparam int unsigned CRC_HOLD_BIT = 5;
  localparam int unsigned GAIN_SRC_BIT = 3;
  localparam int unsigned PIN_SIX = 6;
  localparam int unsigned NUM_PINS = 7;

  // ==========================================================================
  // Values after reset and encodings.
  localparam logic [6:0] RST_STREAM_LEN = 7'h00;
  localparam logic [6:0] RST_DO_START = 7'h1A;
  localparam logic [2:0] RST_DO_COUNT = 3'h2;
  localparam logic [2:0] RST_READY_RSV = 3'h3;
  localparam logic [1:0] PWR_ACTIVE = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;
  localparam logic [1:0] PWR_INVALID = 2'h2;
  localparam logic [1:0] PWR_STANDBY = 2'h3;
  localparam logic [1:0] CAL_OFF = 2'h0;

  // ==========================================================================
  // Timing: settle time of a power mode change.
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PWR_SETTLE_NS = 50;
  localparam int unsigned PWR_SETTLE_CYC = (PWR_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } acrb_reg_req_t;

  typedef struct packed {
    logic link_reset_enable;
    logic stream_kind_select;
    logic [6:0] controlled_stream_length;
    logic [6:0] data_only_start_addr;
    logic [2:0] data_only_byte_count;
    logic [1:0] background_cal_scheme;
    logic crc_clear_hold;
    logic fixed_gain_cal_source;
    logic ready_on_pin_six;
  } acrb_cfg_t;

  typedef enum logic [0:0] {
    PWR_IDLE = 1'b0,
    PWR_SETTLE = 1'b1
  } acrb_pwr_state_t;

endpackage : acrb_pkg

/* File: design/acrb_sync.sv */
// Purpose: Two-stage synchroniser for the general pin inputs.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes: Only the second stage is visible to other logic.
`timescale 1ns/100ps
module acrb_sync
  import acrb_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_PINS
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Data.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acrb_sync_st_t;

  acrb_sync_st_t st_q;
  acrb_sync_st_t st_d;

  // The first stage feeds the second stage and nothing else.
  always_comb begin
    st_d = st_q;
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.sync;

endmodule : acrb_sync

/* File: design/acrb_pwr.sv */
// Purpose: Applies a requested power mode after a settle time.
// Assumes: Requests arrive as one-cycle pulses with a valid encoding.
// Notes: A request during settling restarts the wait with the new target.
`timescale 1ns/100ps
module acrb_pwr
  import acrb_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = PWR_SETTLE_CYC
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Request.
  input wire logic req_i,
  input wire logic [1:0] req_mode_i,
  // Mode in effect.
  output logic [1:0] mode_o
);

  typedef struct packed {
    acrb_pwr_state_t fsm;
    logic [15:0] cnt;
    logic [1:0] target;
    logic [1:0] mode;
  } acrb_pwr_st_t;

  acrb_pwr_st_t st_q;
  acrb_pwr_st_t st_d;

  // The reported mode changes only once the settle count has run out.
  always_comb begin
    st_d = st_q;
    case (st_q.fsm)
      PWR_IDLE: begin
      end
      PWR_SETTLE: begin
        if (st_q.cnt <= 16'h0001) begin
          st_d.mode = st_q.target;
          st_d.fsm = PWR_IDLE;
          st_d.cnt = 16'h0000;
        end else begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end
      end
      default: begin
        st_d.fsm = PWR_IDLE;
      end
    endcase
    if (req_i) begin
      st_d.target = req_mode_i;
      st_d.cnt = SETTLE_CYC[15:0];
      st_d.fsm = PWR_SETTLE;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{fsm: PWR_IDLE, cnt: 16'h0000, target: PWR_ACTIVE, mode: PWR_ACTIVE};
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign mode_o = st_q.mode;

endmodule : acrb_pwr

/* File: design/acrb_regbank.sv */
// Purpose: Control and status register bank of the sensor front-end.
// Assumes: The serial frame decoder on the same clock presents register
//   accesses as one-cycle write or read strobes with address and data.
// Notes: Read data appears one cycle after the read strobe with a valid pulse.
`timescale 1ns/100ps
module acrb_regbank
  import acrb_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = PWR_SETTLE_CYC
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register access from the link decoder.
  input wire acrb_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Configuration towards the converter and link.
  output acrb_cfg_t cfg_o,
  output logic [1:0] pwr_mode_o,
  output logic conv_restart_o,
  output logic crc_clear_o,
  // Data ready from the converter, active low.
  input wire logic data_ready_n_i,
  // General pins.
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);

  // ==========================================================================
  // State.
  typedef struct packed {
    acrb_cfg_t cfg;
    logic link_locked;
    logic [NUM_PINS-1:0] pin_dir;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [7:0] rdata;
    logic rvalid;
    logic restart;
    logic crc_clear;
    logic ready_prev_n;
  } acrb_rb_st_t;

  acrb_rb_st_t st_q;
  acrb_rb_st_t st_d;

  logic [NUM_PINS-1:0] pin_sync;
  logic [1:0] pwr_mode;
  logic pwr_req;
  logic [NUM_PINS-1:0] six_mask;
  logic [NUM_PINS-1:0] drv_out;
  logic [NUM_PINS-1:0] drv_oe;
  logic [NUM_PINS-1:0] gpio_wmask;
  logic [NUM_PINS-1:0] pin_rd;
  logic wr_hit;
  logic [7:0] wd;

  // ==========================================================================
  // Submodules.

  // Pin inputs come from outside and pass two flip-flops first.
  acrb_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // Power mode sequencer reports the mode actually in effect.
  acrb_pwr #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_pwr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .req_i(pwr_req),
    .req_mode_i(reg_req_i.wdata[1:0]),
    .mode_o(pwr_mode)
  );

  // ==========================================================================
  // Access decode.

  // The unused power encoding is dropped rather than passed on.
  assign wr_hit = reg_req_i.wr;
  assign wd = reg_req_i.wdata;
  assign pwr_req = wr_hit && (reg_req_i.addr == OFS_POWER) &&
                   (wd[1:0] != PWR_INVALID);

  // Mask that removes pin six from general use while it carries data ready.
  assign six_mask = st_q.cfg.ready_on_pin_six ?
                    (NUM_PINS'(1) << PIN_SIX) : '0;

  // Level writes only land on pins that are outputs and still general.
  assign gpio_wmask = st_q.pin_dir & ~six_mask;

  // Readback of levels: the present pin value, pin six reads zero when taken.
  assign pin_rd = pin_sync & ~six_mask;

  // ==========================================================================
  // Pin drive, one cell per pin.
  for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_pin
    if (gi == PIN_SIX) begin : g_six
      // Pin six is driven by data ready when routed, whatever its direction.
      assign drv_oe[gi] = st_q.cfg.ready_on_pin_six | st_q.pin_dir[gi];
      assign drv_out[gi] = st_q.cfg.ready_on_pin_six ?
                           data_ready_n_i : st_q.pin_lvl[gi];
    end else begin : g_gen
      // Ordinary pins follow their direction and level bits.
      assign drv_oe[gi] = st_q.pin_dir[gi];
      assign drv_out[gi] = st_q.pin_lvl[gi];
    end
  end

  // ==========================================================================
  // Next state.

  // Register writes, read mux, pulses and pin registers.
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.restart = 1'b0;
    st_d.pin_out = drv_out;
    st_d.pin_oe = drv_oe;
    st_d.ready_prev_n = data_ready_n_i;

    // Deassertion of data ready clears the CRC unless held off.
    st_d.crc_clear = data_ready_n_i && !st_q.ready_prev_n &&
                     !st_q.cfg.crc_clear_hold;

    // Writes.
    if (wr_hit) begin
      case (reg_req_i.addr)
        OFS_LINK_RST: begin
          // Only the first write after register reset takes effect.
          if (!st_q.link_locked) begin
            st_d.cfg.link_reset_enable = wd[LINK_RST_BIT];
            st_d.link_locked = 1'b1;
          end
        end
        OFS_STREAM: begin
          st_d.cfg.stream_kind_select = wd[STRM_KIND_BIT];
          st_d.cfg.controlled_stream_length = wd[6:0];
        end
        OFS_DO_START: begin
          st_d.cfg.data_only_start_addr = wd[6:0];
        end
        OFS_DO_LEN: begin
          st_d.cfg.data_only_byte_count = wd[2:0];
        end
        OFS_RESTART: begin
          st_d.restart = wd[RESTART_BIT];
        end
        OFS_PIN_DIR: begin
          st_d.pin_dir = wd[NUM_PINS-1:0];
        end
        OFS_PIN_DAT: begin
          // Bits of input pins keep their old level silently.
          st_d.pin_lvl = (st_q.pin_lvl & ~gpio_wmask) |
                         (wd[NUM_PINS-1:0] & gpio_wmask);
        end
        OFS_BGCAL: begin
          st_d.cfg.background_cal_scheme = wd[1:0];
        end
        OFS_READY_CTL: begin
          // Reserved bits 6, 4 and 2..0 are not stored.
          st_d.cfg.ready_on_pin_six = wd[READY_PIN6_BIT];
          st_d.cfg.crc_clear_hold = wd[CRC_HOLD_BIT];
          st_d.cfg.fixed_gain_cal_source = wd[GAIN_SRC_BIT];
        end
        default: begin
        end
      endcase
    end

    // Reads; unmapped and write-only addresses return zero.
    if (reg_req_i.rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'h00;
      case (reg_req_i.addr)
        OFS_LINK_RST: begin
          st_d.rdata[LINK_RST_BIT] = st_q.cfg.link_reset_enable;
        end
        OFS_STREAM: begin
          st_d.rdata = {st_q.cfg.stream_kind_select,
                        st_q.cfg.controlled_stream_length};
        end
        OFS_POWER: begin
          st_d.rdata[1:0] = pwr_mode;
        end
        OFS_DO_START: begin
          st_d.rdata[6:0] = st_q.cfg.data_only_start_addr;
        end
        OFS_DO_LEN: begin
          st_d.rdata[2:0] = st_q.cfg.data_only_byte_count;
        end
        OFS_PIN_DIR: begin
          st_d.rdata[NUM_PINS-1:0] = st_q.pin_dir;
        end
        OFS_PIN_DAT: begin
          st_d.rdata[NUM_PINS-1:0] = pin_rd;
        end
        OFS_BGCAL: begin
          st_d.rdata[1:0] = st_q.cfg.background_cal_scheme;
        end
        OFS_READY_CTL: begin
          st_d.rdata[READY_PIN6_BIT] = st_q.cfg.ready_on_pin_six;
          st_d.rdata[CRC_HOLD_BIT] = st_q.cfg.crc_clear_hold;
          st_d.rdata[GAIN_SRC_BIT] = st_q.cfg.fixed_gain_cal_source;
          st_d.rdata[2:0] = RST_READY_RSV;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register.

  // All state is frozen while the clock enable is low.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q.cfg.link_reset_enable <= 1'b0;
      st_q.cfg.stream_kind_select <= 1'b0;
      st_q.cfg.controlled_stream_length <= RST_STREAM_LEN;
      st_q.cfg.data_only_start_addr <= RST_DO_START;
      st_q.cfg.data_only_byte_count <= RST_DO_COUNT;
      st_q.cfg.background_cal_scheme <= CAL_OFF;
      st_q.cfg.crc_clear_hold <= 1'b0;
      st_q.cfg.fixed_gain_cal_source <= 1'b0;
      st_q.cfg.ready_on_pin_six <= 1'b0;
      st_q.link_locked <= 1'b0;
      st_q.pin_dir <= '0;
      st_q.pin_lvl <= '0;
      st_q.pin_out <= '0;
      st_q.pin_oe <= '0;
      st_q.rdata <= 8'h00;
      st_q.rvalid <= 1'b0;
      st_q.restart <= 1'b0;
      st_q.crc_clear <= 1'b0;
      st_q.ready_prev_n <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop.
  assign reg_rdata_o = st_q.rdata;
  assign reg_rvalid_o = st_q.rvalid;
  assign cfg_o = st_q.cfg;
  assign pwr_mode_o = pwr_mode;
  assign conv_restart_o = st_q.restart;
  assign crc_clear_o = st_q.crc_clear;
  assign pin_out_o = st_q.pin_out;
  assign pin_oe_o = st_q.pin_oe;

endmodule : acrb_regbank

/* File: verif/acrb_regbank_props.sv */
// Purpose: Port checks for the register bank.
// Assumes: ce_i is held high while these run.
// Notes: Bound to every acrb_regbank instance.
`timescale 1ns/100ps
module acrb_regbank_props
  import acrb_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = PWR_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched ports.
  input wire acrb_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire acrb_cfg_t cfg_o,
  input wire logic [1:0] pwr_mode_o,
  input wire logic conv_restart_o,
  input wire logic crc_clear_o,
  input wire logic data_ready_n_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o
);
  // ==========================================================================
  // Decoded strobes.
  localparam int PWR_LAT = SETTLE_CYC + 1;
  logic lock_q;
  int pwr_age_q;
  logic [1:0] pwr_tgt_q;
  wire w_any = reg_req_i.wr;
  wire w_lnk = w_any && reg_req_i.addr == OFS_LINK_RST;
  wire w_rst = w_any && reg_req_i.addr == OFS_RESTART && reg_req_i.wdata[0];
  wire w_pwr = w_any && reg_req_i.addr == OFS_POWER && reg_req_i.wdata[1:0] != PWR_INVALID;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Remembers that the link reset bit has been written since reset.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= 1'b0;
    end else if (w_lnk) begin
      lock_q <= 1'b1;
    end
  end

  // Age of the last accepted power request; a newer request restarts the wait.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_age_q <= 0;
      pwr_tgt_q <= PWR_ACTIVE;
    end else if (w_pwr) begin
      pwr_age_q <= 1;
      pwr_tgt_q <= reg_req_i.wdata[1:0];
    end else if (pwr_age_q != 0 && pwr_age_q < PWR_LAT) begin
      pwr_age_q <= pwr_age_q + 1;
    end
  end

  // ==========================================================================
  // Assertions.
  unmapped_read_a: assert property (
    reg_req_i.rd && reg_req_i.addr == 7'h7F |=> reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("Unmapped read did not return zero.");
  stream_cfg_a: assert property (
    w_any && reg_req_i.addr == OFS_STREAM |=> {cfg_o.stream_kind_select,
    cfg_o.controlled_stream_length} == $past(reg_req_i.wdata))
    else $error("Streaming fields did not take the write.");
  power_apply_a: assert property (
    pwr_age_q == PWR_LAT |-> pwr_mode_o == pwr_tgt_q)
    else $error("Power mode not applied after settling.");
  power_code_a: assert property (pwr_mode_o != PWR_INVALID)
    else $error("Power mode shows the unused code.");
  restart_pulse_a: assert property (
    w_rst |=> conv_restart_o ##1 (!conv_restart_o || $past(w_rst)))
    else $error("Restart pulse missing or too long.");
  restart_quiet_a: assert property (!w_rst |=> !conv_restart_o)
    else $error("Restart pulse without a restart write.");
  crc_clear_a: assert property (
    data_ready_n_i && !$past(data_ready_n_i) && !cfg_o.crc_clear_hold |=> crc_clear_o)
    else $error("CRC clear missing on data ready release.");
  crc_hold_a: assert property (cfg_o.crc_clear_hold |=> !crc_clear_o)
    else $error("CRC clear while clearing is suppressed.");
  pin_six_a: assert property (
    cfg_o.ready_on_pin_six |=> pin_oe_o[PIN_SIX] && pin_out_o[PIN_SIX] == $past(data_ready_n_i))
    else $error("Pin six does not carry data ready.");
  link_lock_a: assert property (w_lnk && lock_q |=> $stable(cfg_o.link_reset_enable))
    else $error("Locked link reset bit changed.");
  bgcal_cfg_a: assert property (
    w_any && reg_req_i.addr == OFS_BGCAL |=> cfg_o.background_cal_scheme
    == $past(reg_req_i.wdata[1:0]))
    else $error("Calibration scheme did not take the write.");

  // Main scenarios reached.
  restart_c: cover property (conv_restart_o);
  crc_clear_c: cover property (crc_clear_o);
  power_move_c: cover property (pwr_mode_o != $past(pwr_mode_o));
endmodule : acrb_regbank_props

bind acrb_regbank acrb_regbank_props #(.SETTLE_CYC(SETTLE_CYC)) u_acrb_regbank_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .cfg_o(cfg_o),
  .pwr_mode_o(pwr_mode_o), .conv_restart_o(conv_restart_o), .crc_clear_o(crc_clear_o),
  .data_ready_n_i(data_ready_n_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

/* File: verif/acrb_host.sv */
// Purpose: Host side of the register link, as one-cycle strobes.
// Assumes: Strobes change 1 ns after the rising edge.
// Notes: Idle address and data are inverted so stale values never linger.
`timescale 1ns/100ps
module acrb_host
  import acrb_pkg::*;
(
  // Clock.
  input wire logic sys_clk_i,
  // Register link.
  output acrb_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========================================================================
  // Link cycles.
  initial reg_req_o = '{1'b0, 1'b0, 7'h00, 8'h00};

  // One write strobe, taken at the following edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // One read strobe, then a bounded wait for the valid pulse.
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{1'b0, 1'b0, ~a, 8'hFF};
    for (int i = 0; i < 4 && ok == 1'b0; i++) begin
      if (reg_rvalid_i === 1'b1) begin
        d = reg_rdata_i;
        ok = 1'b1;
      end else begin
        @(posedge sys_clk_i);
        #1;
      end
    end
  endtask : rd
endmodule : acrb_host

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: Power settle shortened to one cycle.
// Notes: Pin levels are resolved from drive enables and external levels.
`timescale 1ns/100ps
module tb
  import acrb_pkg::*;
;
  localparam int unsigned SETTLE = 1;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic drdy_n = 1'b1;
  logic [6:0] ext = 7'h50;
  acrb_reg_req_t req;
  acrb_cfg_t cfg;
  logic [7:0] rdata, rv;
  logic rvalid, restart, crc, ok;
  logic [1:0] pwr;
  logic [6:0] pin_in, pin_out, pin_oe;
  int fails = 0;
  int compares = 0;
  int restarts = 0;
  int clears = 0;
  logic [6:0] ra [10] = '{7'h02, 7'h03, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0E, 7'h10, 7'h11, 7'h7F};
  logic [7:0] rx [10] = '{8'h00, 8'h00, 8'h00, 8'h1A, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] pw [4] = '{8'hFD, 8'h03, 8'h02, 8'h00};
  logic [7:0] pe [4] = '{8'h01, 8'h03, 8'h03, 8'h00};

  // Wire level of each pin: own drive when enabled, else the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  // 200 MHz clock.
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Pulse counters.
  always @(posedge sys_clk_i) begin
    if (restart === 1'b1) restarts++;
    if (crc === 1'b1) clears++;
  end

  acrb_regbank #(.SETTLE_CYC(SETTLE)) u_acrb_regbank (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .cfg_o(cfg), .pwr_mode_o(pwr),
    .conv_restart_o(restart), .crc_clear_o(crc), .data_ready_n_i(drdy_n),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  acrb_host u_acrb_host (.sys_clk_i(sys_clk_i), .reg_req_o(req), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));

  // ==========================================================================
  // Helpers.
  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_acrb_host.wr(a, d);
  endtask : wr

  // Read and compare; a missing valid pulse ends the run.
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    u_acrb_host.rd(a, rv, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("Error read valid at %h expected 1 seen 0", a);
      results();
    end else begin
      chk($sformatf("register %h", a), e, rv);
    end
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic do_reset();
    rst_n_i = 1'b0;
    tick(20);
    rst_n_i = 1'b1;
  endtask : do_reset

  // ==========================================================================
  // Main sequence.
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rchk(ra[i], rx[i]);
    end
    chk("start field", 8'h1A, {1'b0, cfg.data_only_start_addr});
    chk("count field", 8'h02, {5'h00, cfg.data_only_byte_count});
    wr(OFS_STREAM, 8'h85);
    rchk(OFS_STREAM, 8'h85);
    chk("stream kind", 8'h01, {7'h00, cfg.stream_kind_select});
    chk("stream length", 8'h05, {1'b0, cfg.controlled_stream_length});
    wr(OFS_DO_START, 8'hFF);
    rchk(OFS_DO_START, 8'h7F);
    chk("start field", 8'h7F, {1'b0, cfg.data_only_start_addr});
    wr(OFS_DO_LEN, 8'hFF);
    rchk(OFS_DO_LEN, 8'h07);
    chk("count field", 8'h07, {5'h00, cfg.data_only_byte_count});
    for (int i = 0; i < 4; i++) begin
      wr(OFS_POWER, pw[i]);
      tick(SETTLE + 2);
      rchk(OFS_POWER, pe[i]);
      chk("power mode", pe[i], {6'h00, pwr});
    end
    wr(OFS_RESTART, 8'h01);
    wr(OFS_RESTART, 8'hFE);
    wr(OFS_RESTART, 8'h01);
    rchk(OFS_RESTART, 8'h00);
    chk("restart pulses", 8'h02, 8'(restarts));
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BGCAL, {6'h3F, i[1:0]});
      rchk(OFS_BGCAL, {6'h00, i[1:0]});
      chk("cal scheme", {6'h00, i[1:0]}, {6'h00, cfg.background_cal_scheme});
    end
    wr(OFS_PIN_DIR, 8'h8F);
    rchk(OFS_PIN_DIR, 8'h0F);
    wr(OFS_PIN_DAT, 8'hFF);
    tick(4);
    chk("pin enable", 8'h0F, {1'b0, pin_oe});
    chk("pin drive", 8'h0F, {1'b0, pin_out});
    rchk(OFS_PIN_DAT, 8'h5F);
    wr(OFS_PIN_DAT, 8'h05);
    tick(4);
    rchk(OFS_PIN_DAT, 8'h55);
    wr(OFS_PIN_DIR, 8'h40);
    wr(OFS_READY_CTL, 8'h83);
    drdy_n = 1'b0;
    tick(4);
    chk("pin six route", 8'h01, {7'h00, cfg.ready_on_pin_six});
    chk("pin six enable", 8'h01, {7'h00, pin_oe[6]});
    chk("pin six drive", 8'h00, {7'h00, pin_out[6]});
    wr(OFS_PIN_DAT, 8'h40);
    rchk(OFS_PIN_DAT, 8'h10);
    drdy_n = 1'b1;
    tick(3);
    chk("pin six high", 8'h01, {7'h00, pin_out[6]});
    chk("crc clears", 8'h01, 8'(clears));
    wr(OFS_READY_CTL, 8'h2B);
    rchk(OFS_READY_CTL, 8'h2B);
    chk("gain source", 8'h01, {7'h00, cfg.fixed_gain_cal_source});
    chk("crc hold", 8'h01, {7'h00, cfg.crc_clear_hold});
    drdy_n = 1'b0;
    tick(3);
    drdy_n = 1'b1;
    tick(3);
    chk("crc held", 8'h01, 8'(clears));
    chk("pin six general", 8'h00, {7'h00, pin_out[6]});
    wr(OFS_LINK_RST, 8'h01);
    rchk(OFS_LINK_RST, 8'h01);
    chk("link enable", 8'h01, {7'h00, cfg.link_reset_enable});
    wr(OFS_LINK_RST, 8'h00);
    rchk(OFS_LINK_RST, 8'h01);
    do_reset();
    rchk(OFS_LINK_RST, 8'h00);
    rchk(OFS_DO_START, 8'h1A);
    wr(OFS_LINK_RST, 8'h00);
    wr(OFS_LINK_RST, 8'h01);
    rchk(OFS_LINK_RST, 8'h00);
    chk("link enable", 8'h00, {7'h00, cfg.link_reset_enable});
    results();
  end
endmodule : tb
